// ### inc/slcr_regs.svh
// register map, reset values, field positions and codes of the link control
`ifndef SLCR_REGS_SVH
`define SLCR_REGS_SVH

// ==========================================================
// device register addresses
`define SLCR_ADDR_ENABLE   12'h200
`define SLCR_ADDR_MODE     12'h201
`define SLCR_ADDR_SYNC     12'h203
`define SLCR_ADDR_CTRL     12'h204
`define SLCR_ADDR_TEST     12'h205

// ==========================================================
// device reset values
`define SLCR_RST_ENABLE    8'h01
`define SLCR_RST_MODE      8'h00
`define SLCR_RST_SYNC      8'h01
`define SLCR_RST_CTRL      8'h03
`define SLCR_RST_TEST      8'h00

// ==========================================================
// field positions
`define SLCR_BIT_ENABLE    0
`define SLCR_BIT_SOFT_SYNC 0
`define SLCR_BIT_SCR       0
`define SLCR_BIT_FORMAT    1
`define SLCR_SYNC_SEL_HI   3
`define SLCR_SYNC_SEL_LO   2
`define SLCR_BIT_UPPER     4
`define SLCR_TEST_HI       4
`define SLCR_TEST_LO       0
`define SLCR_MASK_SYNC     8'h01
`define SLCR_MASK_CTRL     8'h1F
`define SLCR_MASK_TEST     8'h1F

// ==========================================================
// lane mapping
`define SLCR_UPPER_BASE    4'h4
`define SLCR_UPPER_MAX_L   4'h4

// ==========================================================
// test pattern codes
`define SLCR_TP_NORMAL     5'h00
`define SLCR_TP_K285       5'h07
`define SLCR_TP_ILA        5'h08
`define SLCR_TP_RPAT       5'h09
`define SLCR_TP_LOW        5'h0A
`define SLCR_TP_HIGH       5'h0B
`define SLCR_TP_RSVD       5'h0C
`define SLCR_TP_K287       5'h10
`define SLCR_TP_RSVD_FIRST 5'h11

// ==========================================================
// controller APB map
`define SLCR_APB_CMD       8'h00
`define SLCR_APB_STATUS    8'h04
`define SLCR_APB_MODE      8'h08
`define SLCR_CMD_ADDR_HI   11
`define SLCR_CMD_DATA_LO   12
`define SLCR_CMD_DATA_HI   19
`define SLCR_CMD_WRITE     20
`define SLCR_ST_BUSY       0
`define SLCR_ST_DONE       1
`define SLCR_ST_REFUSED    2
`define SLCR_ST_RDATA_LO   8
`define SLCR_ST_RDATA_HI   15
`define SLCR_MODE_L_HI     3
`define SLCR_MODE_64B      4
`define SLCR_MODE_TSRX     5
`define SLCR_MODE_HI       5

`endif

// ### inc/slcr_pkg.sv
// types shared by both ends of the link control register path
package slcr_pkg;

	// ==========================================================
	// sync request source selection
	typedef enum logic [1:0] {
		SLCR_SRC_SE_PIN = 2'h0,
		SLCR_SRC_TS_PAIR = 2'h1,
		SLCR_SRC_NONE = 2'h2,
		SLCR_SRC_RSVD = 2'h3
	} slcr_sync_src_type;

	// ==========================================================
	// controller sequencer states, gray along the path
	typedef enum logic [1:0] {
		SLCR_IDLE = 2'h0,
		SLCR_REQ = 2'h1,
		SLCR_WAIT = 2'h3,
		SLCR_DONE = 2'h2
	} slcr_state_type;

endpackage

// ### inc/slcr_link_if.sv
// configuration path between the controller and the converter registers
`timescale 1ns/100ps
interface slcr_link_if (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn
);
	logic        cfg_req;
	logic        cfg_write;
	logic [11:0] cfg_addr;
	logic [7:0]  cfg_wdata;
	logic        cfg_ack;
	logic [7:0]  cfg_rdata;

	modport dev (
		input  pclk, presetn, cfg_req, cfg_write, cfg_addr, cfg_wdata,
		output cfg_ack, cfg_rdata
	);
	modport host (
		input  pclk, presetn, cfg_ack, cfg_rdata,
		output cfg_req, cfg_write, cfg_addr, cfg_wdata
	);
endinterface

// ### core/slcr_host.sv
// controller end: APB slave that issues register accesses to the converter
`include "slcr_regs.svh"
`timescale 1ns/100ps
module slcr_host
	import slcr_pkg::*;
(
	// link side
	slcr_link_if.host  link,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr
);
	slcr_state_type state;
	logic [31:0]    cmd;
	logic [7:0]     rdata;
	logic [5:0]     mode;
	logic           done;
	logic           refused;
	logic           shadow_en;
	logic           apb_wr;
	logic           apb_rd;
	logic           start;
	logic           bad;
	logic [11:0]    c_addr;
	logic [7:0]     c_data;
	logic [7:0]     masked;

	assign apb_wr = psel & penable & pwrite;
	assign apb_rd = psel & ~penable & ~pwrite;
	assign c_addr = pwdata[`SLCR_CMD_ADDR_HI:0];
	assign c_data = pwdata[`SLCR_CMD_DATA_HI:`SLCR_CMD_DATA_LO];
	assign start = apb_wr & (paddr == `SLCR_APB_CMD)
		& (state == SLCR_IDLE);

	// reserved bits forced to their zero default
	always_comb begin
		masked = c_data;
		if (c_addr == `SLCR_ADDR_SYNC) begin
			masked = c_data & `SLCR_MASK_SYNC;
		end else if (c_addr == `SLCR_ADDR_CTRL) begin
			masked = c_data & `SLCR_MASK_CTRL;
		end else if (c_addr == `SLCR_ADDR_TEST) begin
			masked = c_data & `SLCR_MASK_TEST;
		end
	end

	// illegal writes are refused, never issued
	always_comb begin
		bad = 1'b0;
		if (pwdata[`SLCR_CMD_WRITE]) begin
			if (shadow_en && (c_addr == `SLCR_ADDR_SYNC
				|| c_addr == `SLCR_ADDR_CTRL
				|| c_addr == `SLCR_ADDR_TEST)) begin
				bad = 1'b1;
			end else if (c_addr == `SLCR_ADDR_CTRL) begin
				if (c_data[`SLCR_BIT_UPPER]
					&& mode[`SLCR_MODE_L_HI:0] > `SLCR_UPPER_MAX_L) begin
					bad = 1'b1;
				end
				if (c_data[`SLCR_SYNC_SEL_HI:`SLCR_SYNC_SEL_LO]
					== SLCR_SRC_TS_PAIR && !mode[`SLCR_MODE_TSRX]) begin
					bad = 1'b1;
				end
			end else if (c_addr == `SLCR_ADDR_TEST
				&& mode[`SLCR_MODE_64B]) begin
				case (c_data[`SLCR_TEST_HI:`SLCR_TEST_LO])
				`SLCR_TP_K285, `SLCR_TP_ILA, `SLCR_TP_RPAT,
				`SLCR_TP_K287: bad = 1'b1;
				default: bad = 1'b0;
				endcase
			end
		end
	end

	// sequencer and link request
	always_ff @(posedge link.pclk or negedge link.presetn) begin
		if (!link.presetn) begin
			state <= SLCR_IDLE;
			link.cfg_req <= 1'b0;
			link.cfg_write <= 1'b0;
			link.cfg_addr <= 12'h000;
			link.cfg_wdata <= 8'h00;
		end else begin
			case (state)
			SLCR_IDLE: begin
				if (start && !bad) begin
					state <= SLCR_REQ;
					link.cfg_req <= 1'b1;
					link.cfg_write <= pwdata[`SLCR_CMD_WRITE];
					link.cfg_addr <= c_addr;
					link.cfg_wdata <= masked;
				end
			end
			SLCR_REQ: begin
				link.cfg_req <= 1'b0;
				state <= SLCR_WAIT;
			end
			SLCR_WAIT: begin
				if (link.cfg_ack) begin
					state <= SLCR_DONE;
				end
			end
			default: state <= SLCR_IDLE;
			endcase
		end
	end

	// command word, read data, enable shadow
	always_ff @(posedge link.pclk or negedge link.presetn) begin
		if (!link.presetn) begin
			cmd <= 32'h0000_0000;
			rdata <= 8'h00;
			shadow_en <= 1'b1;
		end else begin
			if (start) begin
				cmd <= pwdata;
			end
			if (state == SLCR_WAIT && link.cfg_ack) begin
				rdata <= link.cfg_rdata;
				if (link.cfg_write && link.cfg_addr == `SLCR_ADDR_ENABLE) begin
					shadow_en <= link.cfg_wdata[`SLCR_BIT_ENABLE];
				end
			end
		end
	end

	// sticky flags, a set beats a clear in the same cycle
	always_ff @(posedge link.pclk or negedge link.presetn) begin
		if (!link.presetn) begin
			done <= 1'b0;
			refused <= 1'b0;
			mode <= 6'h00;
		end else begin
			if (apb_wr && paddr == `SLCR_APB_STATUS) begin
				done <= done & ~pwdata[`SLCR_ST_DONE];
				refused <= refused & ~pwdata[`SLCR_ST_REFUSED];
			end
			if (state == SLCR_WAIT && link.cfg_ack) begin
				done <= 1'b1;
			end
			if (start && bad) begin
				refused <= 1'b1;
			end
			if (apb_wr && paddr == `SLCR_APB_MODE) begin
				mode <= pwdata[`SLCR_MODE_HI:0];
			end
		end
	end

	// apb read data, zero wait states
	always_ff @(posedge link.pclk or negedge link.presetn) begin
		if (!link.presetn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b1;
			pslverr <= 1'b0;
		end else if (apb_rd) begin
			if (paddr == `SLCR_APB_CMD) begin
				prdata <= cmd;
			end else if (paddr == `SLCR_APB_STATUS) begin
				prdata <= {16'h0000, rdata, 5'h00, refused, done,
					(state != SLCR_IDLE)};
			end else if (paddr == `SLCR_APB_MODE) begin
				prdata <= {26'h0000000, mode};
			end else begin
				prdata <= 32'h0000_0000;
			end
		end
	end
endmodule

// ### core/slcr_device.sv
// converter end: link control registers and the controls they drive
// Function
// - writing zero to soft bit requests sync
// - soft request works under every sync source
// - stuck-low pin cleared by source two or three
// - normal mapping drives lanes 0 to L-1
// - upper mapping drives lanes 4 to 4+L-1
// - upper mapping only for four lanes or fewer
// - sync source field picks pin, pair, none
// - pair source needs timestamp receiver enabled
// - format bit picks offset binary or two's complement
// - scrambler bit enables 8b/10b scrambling
// - 64b/66b always scrambles, ignoring the bit
// - codes 7,8,9,16 only in 8b/10b
// - code 10 holds low, 11 high
// - codes 13,14,15 patterns; 12,17-31 reserved
// - change controls only while link disabled; writes to mode register 12'h201 are not refused while enabled
// - reserved bits written as zero
// - disabled link held reset, powered down, gated
`include "slcr_regs.svh"
`timescale 1ns/100ps
module slcr_device
	import slcr_pkg::*;
#(
	parameter int LANES = 8
)(
	// register side
	slcr_link_if.dev  link,
	// sync request pins, active low, asynchronous
	input  wire logic              single_ended_sync_pin,
	input  wire logic              timestamp_input_pair,
	// mode facts from the mode decoder
	input  wire logic [3:0]        lane_count,
	input  wire logic              mode_64b66b,
	// sync and lanes
	output logic                   sync_request,
	output logic [LANES-1:0]       lane_enable,
	// data path controls
	output logic                   sample_format,
	output logic                   scramble_on,
	output logic [4:0]             pattern_select,
	output logic                   serial_hold_low,
	output logic                   serial_hold_high,
	output logic                   pattern_invalid,
	// link power, reset and mode controls
	output logic                   link_reset,
	output logic                   serializer_power_down,
	output logic                   serializer_clock_off,
	output logic                   multiframe_reset,
	output logic [5:0]             link_mode_select
);
	// ==========================================================
	// register file
	logic [7:0]        enable_reg;
	logic [7:0]        mode_reg;
	logic [7:0]        soft_reg;
	logic [7:0]        link_control;
	logic [7:0]        test_reg;
	logic              wr;
	logic              link_subsystem_enable;
	logic              soft_sync_request_n;
	logic              upper_lane_map;
	slcr_sync_src_type sync_src;
	logic [4:0]        test_pattern_select;

	assign wr = link.cfg_req & link.cfg_write;
	assign link_subsystem_enable = enable_reg[`SLCR_BIT_ENABLE];
	assign soft_sync_request_n = soft_reg[`SLCR_BIT_SOFT_SYNC];
	assign upper_lane_map = link_control[`SLCR_BIT_UPPER];
	assign sync_src = slcr_sync_src_type'(
		link_control[`SLCR_SYNC_SEL_HI:`SLCR_SYNC_SEL_LO]);
	assign test_pattern_select =
		test_reg[`SLCR_TEST_HI:`SLCR_TEST_LO];

	// register writes by address
	always_ff @(posedge link.pclk or negedge link.presetn) begin
		if (!link.presetn) begin
			enable_reg <= `SLCR_RST_ENABLE;
			mode_reg <= `SLCR_RST_MODE;
			soft_reg <= `SLCR_RST_SYNC;
			link_control <= `SLCR_RST_CTRL;
			test_reg <= `SLCR_RST_TEST;
		end else if (wr) begin
			if (link.cfg_addr == `SLCR_ADDR_ENABLE) begin
				enable_reg <= link.cfg_wdata;
			end else if (link.cfg_addr == `SLCR_ADDR_MODE) begin
				mode_reg <= link.cfg_wdata;
			end else if (link.cfg_addr == `SLCR_ADDR_SYNC) begin
				soft_reg <= link.cfg_wdata;
			end else if (link.cfg_addr == `SLCR_ADDR_CTRL) begin
				link_control <= link.cfg_wdata;
			end else if (link.cfg_addr == `SLCR_ADDR_TEST) begin
				test_reg <= link.cfg_wdata;
			end
		end
	end

	// read answer one cycle after the request, zero if unmapped
	always_ff @(posedge link.pclk or negedge link.presetn) begin
		if (!link.presetn) begin
			link.cfg_ack <= 1'b0;
			link.cfg_rdata <= 8'h00;
		end else begin
			link.cfg_ack <= link.cfg_req;
			if (link.cfg_req && !link.cfg_write) begin
				if (link.cfg_addr == `SLCR_ADDR_ENABLE) begin
					link.cfg_rdata <= enable_reg;
				end else if (link.cfg_addr == `SLCR_ADDR_MODE) begin
					link.cfg_rdata <= mode_reg;
				end else if (link.cfg_addr == `SLCR_ADDR_SYNC) begin
					link.cfg_rdata <= soft_reg;
				end else if (link.cfg_addr == `SLCR_ADDR_CTRL) begin
					link.cfg_rdata <= link_control;
				end else if (link.cfg_addr == `SLCR_ADDR_TEST) begin
					link.cfg_rdata <= test_reg;
				end else begin
					link.cfg_rdata <= 8'h00;
				end
			end
		end
	end

	// ==========================================================
	// sync pin synchronisers
	logic [1:0] pin_raw;
	logic [1:0] pin_s1;
	logic [1:0] pin_s2;
	logic [1:0] pin_s3;
	logic [1:0] pin_level;

	assign pin_raw = {timestamp_input_pair, single_ended_sync_pin};

	genvar p;
	generate
		for (p = 0; p < 2; p++) begin : g_pin
			// three stages, level taken once stages two and three agree
			always_ff @(posedge link.pclk or negedge link.presetn) begin
				if (!link.presetn) begin
					pin_s1[p] <= 1'b1;
					pin_s2[p] <= 1'b1;
					pin_s3[p] <= 1'b1;
					pin_level[p] <= 1'b1;
				end else begin
					pin_s1[p] <= pin_raw[p];
					pin_s2[p] <= pin_s1[p];
					pin_s3[p] <= pin_s2[p];
					if (pin_s2[p] == pin_s3[p]) begin
						pin_level[p] <= pin_s3[p];
					end
				end
			end
		end
	endgenerate

	// ==========================================================
	// effective sync request
	logic pin_request;

	// selected pin, low means request
	always_comb begin
		case (sync_src)
		SLCR_SRC_SE_PIN:  pin_request = ~pin_level[0];
		SLCR_SRC_TS_PAIR: pin_request = ~pin_level[1];
		default:          pin_request = 1'b0;
		endcase
	end

	// soft request ored in under any source
	always_ff @(posedge link.pclk or negedge link.presetn) begin
		if (!link.presetn) begin
			sync_request <= 1'b0;
		end else begin
			sync_request <= pin_request | ~soft_sync_request_n;
		end
	end

	// ==========================================================
	// lane mapping, one flop per lane
	genvar i;
	generate
		for (i = 0; i < LANES; i++) begin : g_lane
			localparam logic [4:0] IDX = 5'(i);
			always_ff @(posedge link.pclk or negedge link.presetn) begin
				if (!link.presetn) begin
					lane_enable[i] <= 1'b0;
				end else if (!link_subsystem_enable) begin
					lane_enable[i] <= 1'b0;
				end else if (upper_lane_map) begin
					lane_enable[i] <= (IDX >= {1'b0, `SLCR_UPPER_BASE})
						&& (IDX < {1'b0, `SLCR_UPPER_BASE}
						+ {1'b0, lane_count});
				end else begin
					lane_enable[i] <= IDX < {1'b0, lane_count};
				end
			end
		end
	endgenerate

	// ==========================================================
	// data path controls
	logic tp_8b_only;
	logic tp_reserved;

	// codes that need 8b/10b, and reserved codes
	always_comb begin
		tp_8b_only = 1'b0;
		case (test_pattern_select)
		`SLCR_TP_K285, `SLCR_TP_ILA, `SLCR_TP_RPAT,
		`SLCR_TP_K287: tp_8b_only = 1'b1;
		default: tp_8b_only = 1'b0;
		endcase
		tp_reserved = (test_pattern_select == `SLCR_TP_RSVD)
			|| (test_pattern_select >= `SLCR_TP_RSVD_FIRST);
	end

	// format, scrambling and pattern selection
	always_ff @(posedge link.pclk or negedge link.presetn) begin
		if (!link.presetn) begin
			sample_format <= 1'b0;
			scramble_on <= 1'b0;
			pattern_select <= `SLCR_TP_NORMAL;
			serial_hold_low <= 1'b0;
			serial_hold_high <= 1'b0;
			pattern_invalid <= 1'b0;
			link_mode_select <= 6'h00;
		end else begin
			sample_format <= link_control[`SLCR_BIT_FORMAT];
			scramble_on <= mode_64b66b
				| link_control[`SLCR_BIT_SCR];
			serial_hold_low <= test_pattern_select == `SLCR_TP_LOW;
			serial_hold_high <= test_pattern_select == `SLCR_TP_HIGH;
			pattern_invalid <= tp_reserved | (tp_8b_only & mode_64b66b);
			if (tp_reserved || (tp_8b_only && mode_64b66b)) begin
				pattern_select <= `SLCR_TP_NORMAL;
			end else begin
				pattern_select <= test_pattern_select;
			end
			link_mode_select <= mode_reg[`SLCR_MODE_HI:0];
		end
	end

	// ==========================================================
	// disabled link held in reset, serializers off
	always_ff @(posedge link.pclk or negedge link.presetn) begin
		if (!link.presetn) begin
			link_reset <= 1'b1;
			serializer_power_down <= 1'b1;
			serializer_clock_off <= 1'b1;
			multiframe_reset <= 1'b1;
		end else begin
			link_reset <= ~link_subsystem_enable;
			serializer_power_down <= ~link_subsystem_enable;
			serializer_clock_off <= ~link_subsystem_enable;
			multiframe_reset <= ~link_subsystem_enable;
		end
	end
endmodule

// ### verif/slcr_asserts.sv
// interface checker for the link control register path
`timescale 1ns/100ps
module slcr_asserts (
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// config path
	input wire logic        cfg_req,
	input wire logic        cfg_write,
	input wire logic [11:0] cfg_addr,
	input wire logic [7:0]  cfg_wdata,
	input wire logic        cfg_ack,
	input wire logic [7:0]  cfg_rdata
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [7:0] en, sy, ct, ts, exp_rd;
	logic       wr, rd, hit;

	// ====================
	// mirror of issued writes
	assign wr = cfg_req && cfg_write;
	assign rd = cfg_req && !cfg_write;
	assign hit = cfg_addr inside {12'h200, 12'h203, 12'h204, 12'h205};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en <= 8'h01;
			sy <= 8'h01;
			ct <= 8'h03;
			ts <= 8'h00;
		end else if (wr) begin
			if (cfg_addr == 12'h200) en <= cfg_wdata;
			if (cfg_addr == 12'h203) sy <= cfg_wdata;
			if (cfg_addr == 12'h204) ct <= cfg_wdata;
			if (cfg_addr == 12'h205) ts <= cfg_wdata;
		end
	end
	// stored value for the current address
	always_comb begin
		case (cfg_addr)
			12'h200: exp_rd = en;
			12'h203: exp_rd = sy;
			12'h204: exp_rd = ct;
			default: exp_rd = ts;
		endcase
	end

	// ====================
	// assertions
	a_ack_next: assert property (cfg_req |=> cfg_ack)
		else $error("ack missing after request");
	a_ack_cause: assert property (cfg_ack |-> $past(cfg_req))
		else $error("ack without request");
	a_req_spaced: assert property (cfg_req |=> !cfg_req [*2])
		else $error("requests too close");
	a_read_back: assert property (
		rd && hit |=> cfg_rdata == $past(exp_rd))
		else $error("read data differs from stored value");
	a_sync_rsvd: assert property (
		wr && cfg_addr == 12'h203 |-> cfg_wdata[7:1] == 7'h00)
		else $error("sync reserved bits written nonzero");
	a_ctrl_rsvd: assert property (
		wr && cfg_addr == 12'h204 |-> cfg_wdata[7:5] == 3'h0)
		else $error("control reserved bits written nonzero");
	a_test_rsvd: assert property (
		wr && cfg_addr == 12'h205 |-> cfg_wdata[7:5] == 3'h0)
		else $error("test reserved bits written nonzero");
	a_cfg_disabled: assert property (
		wr && cfg_addr inside {12'h203, 12'h204, 12'h205} |-> !en[0])
		else $error("control written while link enabled");
	c_wr_ctrl: cover property (wr && cfg_addr == 12'h204);
	c_read: cover property (rd && hit);
	c_disable: cover property (wr && cfg_addr == 12'h200 && !cfg_wdata[0]);
endmodule

// ### verif/tb_serial_link_control_regs.sv
// self-checking bench for both ends of the link control path
`timescale 1ns/100ps
module tb_serial_link_control_regs;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        se_pin, ts_pin, b64, sync_request, sample_format;
	logic        scramble_on, hold_lo, hold_hi, pat_bad, ok, obs_stb;
	logic        link_reset, ser_pd, ser_ck, mf_rst;
	logic [3:0]  lcnt, l;
	logic [4:0]  pat;
	logic [5:0]  lmode;
	logic [7:0]  paddr, lanes;
	logic [31:0] pwdata, prdata, obs, r, st;
	logic [11:0] ra[3] = '{12'h203, 12'h204, 12'h205};
	logic [7:0]  rv[3] = '{8'h01, 8'h03, 8'h00};
	int          fails, num_checks, cyc;
	logic [31:0] exp_q[$];
	string       nam_q[$];

	// ====================
	// both ends and the checker
	slcr_link_if slcr_link_if_i (.pclk(pclk), .presetn(presetn));
	slcr_host slcr_host_i (.link(slcr_link_if_i), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr));
	slcr_device #(.LANES(8)) slcr_device_i (.link(slcr_link_if_i),
		.single_ended_sync_pin(se_pin), .timestamp_input_pair(ts_pin),
		.lane_count(lcnt), .mode_64b66b(b64), .sync_request(sync_request),
		.lane_enable(lanes), .sample_format(sample_format),
		.scramble_on(scramble_on), .pattern_select(pat),
		.serial_hold_low(hold_lo), .serial_hold_high(hold_hi),
		.pattern_invalid(pat_bad), .link_reset(link_reset),
		.serializer_power_down(ser_pd), .serializer_clock_off(ser_ck),
		.multiframe_reset(mf_rst), .link_mode_select(lmode));
	slcr_asserts slcr_asserts_i (.pclk(pclk), .presetn(presetn),
		.cfg_req(slcr_link_if_i.cfg_req),
		.cfg_write(slcr_link_if_i.cfg_write),
		.cfg_addr(slcr_link_if_i.cfg_addr),
		.cfg_wdata(slcr_link_if_i.cfg_wdata),
		.cfg_ack(slcr_link_if_i.cfg_ack),
		.cfg_rdata(slcr_link_if_i.cfg_rdata));

	// clock
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	// ====================
	// tasks
	task automatic stop_test();
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic check(string n, logic [31:0] s, logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			fails++;
			$display("MISMATCH %s exp %h seen %h", n, e, s);
		end
	endtask
	// note the expectation, then present what was seen
	task automatic expect_v(string n, logic [31:0] e, logic [31:0] v);
		nam_q.push_back(n);
		exp_q.push_back(e);
		obs <= v;
		obs_stb <= 1'b1;
		@(posedge pclk);
		obs_stb <= 1'b0;
		@(posedge pclk);
	endtask
	// one apb transfer, read data left in r
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// issue a device access and wait for it, status left in st
	task automatic cmd(logic w, logic [11:0] a, logic [7:0] d);
		apb(1'b1, 8'h00, {11'h0, w, d, a});
		do apb(1'b0, 8'h04, 32'h0); while (r[0] !== 1'b0);
		st = r;
		apb(1'b1, 8'h04, 32'h6);
	endtask
	task automatic set_mode(logic [3:0] n, logic b, logic t);
		lcnt <= n;
		b64 <= b;
		apb(1'b1, 8'h08, {26'h0, t, b, n});
	endtask

	// result watcher and hang limit
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails = fails + 1;
			stop_test();
		end
		if (obs_stb)
			check(nam_q.pop_front(), obs, exp_q.pop_front());
	end

	// ====================
	// main sequence
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{se_pin, ts_pin, b64, obs_stb, obs} = 36'hC_0000_0000;
		lcnt = 4'h2;
		fails = 0;
		num_checks = 0;
		cyc = 0;
		r = $urandom(32'hFF6B682F);
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		set_mode(4'h2, 1'b0, 1'b1);
		repeat (8) @(posedge pclk);
		expect_v("lanes", 32'h03, lanes);
		expect_v("fmt scr", 32'h3, {sample_format, scramble_on});
		expect_v("sync", 32'h0, sync_request);
		foreach (ra[i]) begin
			cmd(1'b0, ra[i], 8'h00);
			expect_v("reset val", rv[i], st[15:8]);
		end
		cmd(1'b1, 12'h204, 8'h00);
		expect_v("refused", 32'h1, st[2]);
		cmd(1'b1, 12'h200, 8'h00);
		repeat (3) @(posedge pclk);
		expect_v("link off", 32'h1F, {link_reset, ser_pd, ser_ck, mf_rst,
			lanes == 8'h00});
		// software request under the pin, pair and none sources
		for (int s = 0; s < 3; s++) begin
			cmd(1'b1, 12'h204, {4'h0, s[1:0], 2'h3});
			cmd(1'b1, 12'h203, 8'h00);
			repeat (8) @(posedge pclk);
			expect_v("soft sync", 32'h1, sync_request);
			cmd(1'b1, 12'h203, 8'hFF);
			repeat (8) @(posedge pclk);
			expect_v("sync idle", 32'h0, sync_request);
		end
		cmd(1'b0, 12'h203, 8'h00);
		expect_v("sync mask", 32'h01, st[15:8]);
		// pin held low, then masked by source two
		for (int s = 0; s < 2; s++) begin
			se_pin <= (s != 0);
			ts_pin <= (s == 0);
			cmd(1'b1, 12'h204, {4'h0, s[1:0], 2'h3});
			repeat (8) @(posedge pclk);
			expect_v("pin sync", 32'h1, sync_request);
			cmd(1'b1, 12'h204, 8'h0B);
			repeat (8) @(posedge pclk);
			expect_v("pin masked", 32'h0, sync_request);
		end
		se_pin <= 1'b1;
		ts_pin <= 1'b1;
		cmd(1'b1, 12'h204, 8'hE3);
		cmd(1'b0, 12'h204, 8'h00);
		expect_v("ctrl mask", 32'h03, st[15:8]);
		// format and scrambling in both codings
		for (int i = 0; i < 8; i++) begin
			set_mode(4'h2, i[2], 1'b1);
			cmd(1'b1, 12'h204, {6'h0, i[1:0]});
			repeat (3) @(posedge pclk);
			expect_v("fmt scr", {i[1], i[0] | i[2]},
				{sample_format, scramble_on});
		end
		// normal and upper lane mapping, random lane count
		for (int k = 0; k < 2; k++) begin
			l = 4'($urandom_range(k ? 4 : 8, 1));
			set_mode(l, 1'b0, 1'b1);
			cmd(1'b1, 12'h204, k ? 8'h13 : 8'h03);
			cmd(1'b1, 12'h200, 8'h01);
			repeat (3) @(posedge pclk);
			expect_v("lanes", ((32'h1 << l) - 1) << (k * 4), lanes);
			cmd(1'b1, 12'h200, 8'h00);
		end
		set_mode(4'h6, 1'b0, 1'b1);
		cmd(1'b1, 12'h204, 8'h13);
		expect_v("upper L6", 32'h1, st[2]);
		// every test code
		set_mode(4'h2, 1'b0, 1'b1);
		for (int c = 0; c < 32; c++) begin
			cmd(1'b1, 12'h205, c[7:0] | 8'hE0);
			repeat (3) @(posedge pclk);
			ok = !(c == 12 || c > 16);
			expect_v("pattern", {!ok, c == 11, c == 10, ok ? c[4:0] : 5'h0},
				{pat_bad, hold_hi, hold_lo, pat});
		end
		set_mode(4'h2, 1'b1, 1'b1);
		cmd(1'b1, 12'h205, 8'h10);
		expect_v("64b code", 32'h1, st[2]);
		cmd(1'b0, 12'h3FF, 8'h00);
		expect_v("cfg unmapped", 32'h0, st[15:8]);
		apb(1'b0, 8'h0C, 32'h0);
		expect_v("apb unmapped", 32'h0, r);
		expect_v("pslverr", 32'h0, pslverr);
		apb(1'b0, 8'h08, 32'h0);
		expect_v("mode reg", 32'h32, r);
		// pair source refused without the timestamp receiver
		set_mode(4'h2, 1'b0, 1'b0);
		cmd(1'b1, 12'h204, 8'h07);
		expect_v("pair no rx", 32'h1, st[2]);
		// mode register reaches the mode select output
		cmd(1'b1, 12'h201, 8'h2A);
		repeat (3) @(posedge pclk);
		expect_v("mode sel", 32'h2A, lmode);
		apb(1'b0, 8'h00, 32'h0);
		expect_v("cmd word", 32'h0012_A201, r);
		stop_test();
	end
endmodule
